// file: bench/acm_clock_source.sv
// Host audio source model driving bit and frame clocks
`timescale 1ns/1ps
module acm_clock_source (
  input wire logic run,
  input wire logic [31:0] half_ns,
  input wire logic [31:0] bits,
  output logic bit_clock,
  output logic frame_clock
);
  // ****************************************
  // Frames of bits, clocks idle low when stopped
  // ****************************************
  initial begin
    bit_clock = 1'b0;
    frame_clock = 1'b0;
    #7;
    forever begin
      if (run) begin
        for (int i = 0; i < bits; i++) begin
          frame_clock = (i < bits / 2);
          #(half_ns) bit_clock = 1'b1;
          #(half_ns) bit_clock = 1'b0;
        end
      end else begin
        frame_clock = 1'b0;
        #(half_ns);
      end
    end
  end
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the audio clock monitor
`timescale 1ns/1ps
module tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0, ratio, mode;
  logic awready, wready, bvalid, arready, rvalid, bit_clock, frame_clock, clock_error;
  logic [1:0] bresp, rresp, r;
  logic [31:0] d;
  logic run = 1'b0;
  int half_ns = 160, bits = 64, error_cnt = 0, tests_run = 0, cyc = 0;
  always #20 clk = ~clk;
  acm_clock_source acm_clock_source_i (.run(run), .half_ns(half_ns), .bits(bits),
    .bit_clock(bit_clock), .frame_clock(frame_clock));
  acm_monitor acm_monitor_i (.clk(clk), .reset_n(reset_n), .bit_clock(bit_clock), .frame_clock(frame_clock),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bit_clocks_per_frame(ratio), .sample_rate_mode(mode), .clock_error(clock_error));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic end_sim();
    $display("Checks %0d, errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic setm(input logic [7:0] m);
    wr(12'ha4, {24'h0, m});
    repeat (4) @(posedge clk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    chk(clock_error, 1'b0, "clock_error after reset");
    rd(12'ha0);
    chk(d, 32'h0, "ratio_rate reset");
    chk(r, acm_pkg::RESP_OKAY, "mapped read resp");
    rd(12'ha4);
    chk(d, 32'h0, "masks reset");
    rd(12'hfc);
    chk(r, acm_pkg::RESP_SLVERR, "unmapped read resp");
    wr(12'hfc, 32'h1);
    chk(r, acm_pkg::RESP_SLVERR, "unmapped write resp");
  endtask
  task automatic t_codes();
    logic [3:0] rc [5] = '{4'h3, 4'h5, 4'h7, 4'h9, 4'hb};
    logic [3:0] mc [7] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9, 4'hb};
    for (int i = 0; i < 7; i++) begin
      wr(12'ha0, {24'h0, rc[i % 5], mc[i]});
      chk(r, acm_pkg::RESP_OKAY, "mapped write resp");
      chk(ratio, rc[i % 5], "ratio field");
      chk(mode, mc[i], "mode field");
      rd(12'ha0);
      chk(d, {24'h0, rc[i % 5], mc[i]}, "ratio_rate readback");
    end
  endtask
  task automatic t_good();
    run <= 1'b1;
    wr(12'ha0, 32'h59);
    repeat (3000) @(posedge clk);
    rd(12'ha8);
    chk(d & 32'hff3f, 32'h5900, "status with good clocks");
    chk(clock_error, 1'b0, "no clock error");
  endtask
  task automatic t_rate();
    wr(12'ha0, 32'h54);
    repeat (1500) @(posedge clk);
    rd(12'ha8);
    chk(d[2], 1'b1, "rate error flagged");
    chk(clock_error, 1'b1, "rate error counts");
    setm(8'h10);
    chk(clock_error, 1'b0, "rate error masked");
    rd(12'ha8);
    chk(d[2], 1'b1, "rate error still shown");
    setm(8'h00);
    wr(12'ha0, 32'h50);
    repeat (1500) @(posedge clk);
    chk(clock_error, 1'b0, "auto detection accepts");
    wr(12'ha0, 32'h51);
    repeat (1500) @(posedge clk);
    rd(12'ha8);
    chk(d[2], 1'b1, "reserved mode flagged");
    bits = 32;
    wr(12'ha0, 32'h3b);
    repeat (1500) @(posedge clk);
    chk(clock_error, 1'b0, "96k mode accepts");
  endtask
  task automatic t_ratio();
    bits = 16;
    repeat (1500) @(posedge clk);
    rd(12'ha8);
    chk(d[3], 1'b1, "ratio below 32 flagged");
    setm(8'h10);
    chk(clock_error, 1'b1, "ratio error counts");
    setm(8'h18);
    chk(clock_error, 1'b0, "ratio error masked");
    bits = 64;
  endtask
  task automatic t_pll();
    half_ns = 40;
    repeat (2000) @(posedge clk);
    rd(12'ha8);
    chk(d[0], 1'b1, "pll overrate flagged");
    setm(8'h3c);
    chk(clock_error, 1'b1, "pll overrate counts");
    setm(8'h7c);
    chk(clock_error, 1'b0, "pll overrate masked");
    bits = 600;
    repeat (3000) @(posedge clk);
    rd(12'ha8);
    chk(d[3], 1'b1, "ratio above 512 flagged");
    bits = 64;
    half_ns = 160;
  endtask
  task automatic t_miss();
    run <= 1'b0;
    setm(8'h00);
    repeat (5000) @(posedge clk);
    rd(12'ha8);
    chk(d[4] & d[1], 1'b1, "missing and range flagged");
    setm(8'h3c);
    chk(clock_error, 1'b0, "missing and range masked");
    setm(8'h38);
    chk(clock_error, 1'b1, "missing counts");
    setm(8'h1c);
    chk(clock_error, 1'b1, "range counts");
  endtask
  task automatic t_rst2();
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    chk(clock_error, 1'b0, "clock_error after second reset");
    rd(12'ha4);
    chk(d, 32'h0, "masks after second reset");
    rd(12'ha0);
    chk(d, 32'h0, "ratio_rate after second reset");
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_codes();
    t_good();
    t_rate();
    t_ratio();
    t_pll();
    t_miss();
    t_rst2();
    end_sim();
  end
endmodule

// file: logic/acm_axil_slave.sv
// AXI4-Lite slave handshake for the clock monitor registers
`timescale 1ns/1ps
module acm_axil_slave (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [acm_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [acm_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [acm_pkg::ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [acm_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_held;
  logic w_held;
  wire aw_fire = awvalid & awready;
  wire w_fire = wvalid & wready;
  wire b_fire = bvalid & bready;
  wire ar_fire = arvalid & arready;
  wire r_fire = rvalid & rready;

  assign wr_en = aw_held & w_held & ~bvalid;
  assign rd_addr = araddr;

  // ****************************************
  // Write channels
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      bvalid <= 1'b0;
      bresp <= acm_pkg::RESP_OKAY;
    end else begin
      if (aw_fire) begin
        wr_addr <= awaddr;
        aw_held <= 1'b1;
        awready <= 1'b0;
      end
      if (w_fire) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
        w_held <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_en) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? acm_pkg::RESP_OKAY : acm_pkg::RESP_SLVERR;
      end
      if (b_fire) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // ****************************************
  // Read channels
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= acm_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_data;
      rresp <= rd_ok ? acm_pkg::RESP_OKAY : acm_pkg::RESP_SLVERR;
    end else if (r_fire) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end
endmodule

// file: logic/acm_monitor.sv
// Audio clock configuration registers and incoming clock fault monitor
`timescale 1ns/1ps
// Operation
// [RULE1] Bits 7-4 hold configured bit clocks per frame, codes for 32 to 512 FS.
// [RULE2] Bits 3-0 select sample rate mode; 0000 automatic, others fixed or reserved.
// [RULE3] Software programs the rate mode to match the delivered rate unless automatic.
// [RULE4] Flag PLL overrate whenever the PLL runs at or above 150 MHz.
// [RULE5] Mask bit 6 set keeps PLL overrate out of the clock error.
// [RULE6] Flag range error unless bit clock stays between 256 kHz and 50 MHz.
// [RULE7] Mask bit 5 set keeps bit clock range error out of the clock error.
// [RULE8] Mask bit 4 set hides sample rate error from clock error, status still shows it.
// [RULE9] Flag ratio error unless bit clocks per frame stay stable within 32 to 512.
// [RULE10] Mask bit 3 set keeps ratio error out of the clock error.
// [RULE11] Detect missing bit clock; mask bit 2 set keeps it out of clock error.
// [RULE12] Clock error is the OR of unmasked detections; all masks clear after reset.
// [RULE13] Software releases the processor only after all input clocks have settled.
module acm_monitor #(
  parameter int PLL_MULT = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bit_clock,
  input wire logic frame_clock,
  input wire logic [acm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [acm_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [3:0] bit_clocks_per_frame,
  output logic [3:0] sample_rate_mode,
  output logic clock_error
);
  localparam int PLL_PER_CYC = int'((64'(acm_pkg::CLK_HZ) * PLL_MULT) / acm_pkg::PLL_LIMIT_HZ);
  localparam int MISS_CYC = acm_pkg::MISS_CYC;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [1:0] reg_sel(input logic [acm_pkg::ADDR_W-1:0] a);
    logic [1:0] s;
    s = 2'h0;
    if (a[acm_pkg::ADDR_W-1:10] == '0) begin
      if (a[9:2] == acm_pkg::IDX_RATIO_RATE) s = 2'h1;
      if (a[9:2] == acm_pkg::IDX_MASKS) s = 2'h2;
      if (a[9:2] == acm_pkg::IDX_STATUS) s = 2'h3;
    end
    return s;
  endfunction

  function automatic logic fs_match(input logic [3:0] mode, input logic [acm_pkg::FRAME_CNT_W-1:0] per);
    int p;
    int lo;
    int hi;
    p = int'(per);
    lo = 1;
    hi = 0;
    case (mode)
      acm_pkg::MODE_8K: begin
        lo = acm_pkg::fs_lo(acm_pkg::FS_8K_HZ);
        hi = acm_pkg::fs_hi(acm_pkg::FS_8K_HZ);
      end
      acm_pkg::MODE_16K: begin
        lo = acm_pkg::fs_lo(acm_pkg::FS_16K_HZ);
        hi = acm_pkg::fs_hi(acm_pkg::FS_16K_HZ);
      end
      acm_pkg::MODE_32K: begin
        lo = acm_pkg::fs_lo(acm_pkg::FS_32K_HZ);
        hi = acm_pkg::fs_hi(acm_pkg::FS_32K_HZ);
      end
      acm_pkg::MODE_44K1: begin
        lo = acm_pkg::fs_lo(acm_pkg::FS_44K1_HZ);
        hi = acm_pkg::fs_hi(acm_pkg::FS_44K1_HZ);
      end
      acm_pkg::MODE_48K: begin
        lo = acm_pkg::fs_lo(acm_pkg::FS_48K_HZ);
        hi = acm_pkg::fs_hi(acm_pkg::FS_48K_HZ);
      end
      acm_pkg::MODE_96K: begin
        lo = acm_pkg::fs_lo(acm_pkg::FS_96K_HZ);
        hi = acm_pkg::fs_hi(acm_pkg::FS_88K2_HZ);
      end
      default: begin
        lo = 1;
        hi = 0;
      end
    endcase
    return (p >= lo) && (p <= hi);
  endfunction

  function automatic logic [3:0] fs_detect(input logic [acm_pkg::FRAME_CNT_W-1:0] per);
    logic [3:0] m;
    m = acm_pkg::MODE_AUTO;
    if (fs_match(acm_pkg::MODE_8K, per)) m = acm_pkg::MODE_8K;
    if (fs_match(acm_pkg::MODE_16K, per)) m = acm_pkg::MODE_16K;
    if (fs_match(acm_pkg::MODE_32K, per)) m = acm_pkg::MODE_32K;
    if (fs_match(acm_pkg::MODE_44K1, per)) m = acm_pkg::MODE_44K1;
    if (fs_match(acm_pkg::MODE_48K, per)) m = acm_pkg::MODE_48K;
    if (fs_match(acm_pkg::MODE_96K, per)) m = acm_pkg::MODE_96K;
    return m;
  endfunction

  function automatic logic [3:0] ratio_code(input logic [acm_pkg::BITS_W-1:0] n);
    logic [3:0] c;
    c = 4'h0;
    if (n == 10'd32) c = acm_pkg::RATIO_32FS;
    if (n == 10'd64) c = acm_pkg::RATIO_64FS;
    if (n == 10'd128) c = acm_pkg::RATIO_128FS;
    if (n == 10'd256) c = acm_pkg::RATIO_256FS;
    if (n == 10'd512) c = acm_pkg::RATIO_512FS;
    return c;
  endfunction

  // ****************************************
  // Synchronisers and edge detect
  // ****************************************
  logic [2:0] bclk_sync;
  logic [2:0] fclk_sync;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bclk_sync <= 3'h0;
      fclk_sync <= 3'h0;
    end else begin
      bclk_sync <= {bclk_sync[1:0], bit_clock};
      fclk_sync <= {fclk_sync[1:0], frame_clock};
    end
  end
  wire bclk_rise = bclk_sync[1] & ~bclk_sync[2];
  wire frame_rise = fclk_sync[1] & ~fclk_sync[2];

  // ****************************************
  // Bit clock period, range, PLL and missing checks
  // ****************************************
  logic [acm_pkg::PER_W-1:0] bclk_cnt;
  logic pll_over;
  logic range_err;
  logic missing;
  wire [acm_pkg::PER_W-1:0] per_now = bclk_cnt + 8'h01;
  wire cnt_sat = (int'(bclk_cnt) >= MISS_CYC - 1);
  wire too_slow = (int'(per_now) > acm_pkg::BCLK_MAX_PER_CYC);
  wire too_fast = (int'(per_now) < acm_pkg::BCLK_MIN_PER_CYC);
  wire next_pll = (int'(per_now) <= PLL_PER_CYC);
  wire next_range = bclk_rise ? (too_slow | too_fast) : (too_slow | range_err);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bclk_cnt <= '0;
      pll_over <= 1'b0;
      range_err <= 1'b0;
      missing <= 1'b0;
    end else begin
      bclk_cnt <= bclk_rise ? '0 : (cnt_sat ? bclk_cnt : per_now);
      pll_over <= bclk_rise ? next_pll : (pll_over & ~cnt_sat); // [RULE4]
      range_err <= next_range; // [RULE6]
      missing <= bclk_rise ? 1'b0 : (cnt_sat | missing); // [RULE11]
    end
  end

  // ****************************************
  // Frame checks: ratio and sample rate
  // ****************************************
  logic [acm_pkg::BITS_W-1:0] bits_cnt;
  logic [acm_pkg::BITS_W-1:0] bits_prev;
  logic [acm_pkg::FRAME_CNT_W-1:0] frame_cnt;
  logic ratio_err;
  logic fs_err;
  logic [3:0] mode_seen;
  logic [3:0] ratio_seen;
  logic [7:0] ratio_rate;
  logic [7:0] masks;
  wire [acm_pkg::BITS_W-1:0] bits_now = (bits_cnt == '1) ? bits_cnt : bits_cnt + {9'h0, bclk_rise};
  wire [acm_pkg::FRAME_CNT_W-1:0] frame_per = frame_cnt + 12'h001;
  wire frame_sat = (frame_cnt == '1);
  wire ratio_bad = (int'(bits_now) < acm_pkg::RATIO_MIN) || (int'(bits_now) > acm_pkg::RATIO_MAX) ||
                   (bits_now != bits_prev);
  wire [3:0] mode_now = fs_detect(frame_per);
  wire auto_mode = (ratio_rate[3:0] == acm_pkg::MODE_AUTO);
  wire fs_bad = auto_mode ? (mode_now == acm_pkg::MODE_AUTO) : ~fs_match(ratio_rate[3:0], frame_per);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bits_cnt <= '0;
      bits_prev <= '0;
      frame_cnt <= '0;
      ratio_err <= 1'b0;
      fs_err <= 1'b0;
      mode_seen <= acm_pkg::MODE_AUTO;
      ratio_seen <= 4'h0;
    end else if (frame_rise) begin
      bits_cnt <= '0;
      bits_prev <= bits_now;
      frame_cnt <= '0;
      ratio_err <= ratio_bad; // [RULE9]
      fs_err <= fs_bad; // [RULE2]
      mode_seen <= mode_now;
      ratio_seen <= ratio_code(bits_now);
    end else begin
      bits_cnt <= bits_now;
      frame_cnt <= frame_sat ? frame_cnt : frame_per;
      ratio_err <= ratio_err | frame_sat;
      fs_err <= fs_err | frame_sat;
    end
  end

  // ****************************************
  // Combined clock error
  // ****************************************
  wire [4:0] raw = {pll_over, range_err, fs_err, ratio_err, missing};
  wire [4:0] mask_sel = {masks[acm_pkg::MASK_PLL_BIT], masks[acm_pkg::MASK_RANGE_BIT],
                         masks[acm_pkg::MASK_FS_BIT], masks[acm_pkg::MASK_RATIO_BIT],
                         masks[acm_pkg::MASK_MISS_BIT]};
  wire next_clock_error = |(raw & ~mask_sel); // [RULE5] [RULE7] [RULE8] [RULE10] [RULE11]
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clock_error <= 1'b0;
    end else begin
      clock_error <= next_clock_error; // [RULE12]
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  logic wr_en;
  logic [acm_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [acm_pkg::ADDR_W-1:0] rd_addr;
  wire [1:0] wr_sel = reg_sel(wr_addr);
  wire [1:0] rd_sel = reg_sel(rd_addr);
  wire wr_ok = (wr_sel == 2'h1) || (wr_sel == 2'h2) || (wr_sel == 2'h3);
  wire rd_ok = (rd_sel != 2'h0);
  wire wr_low = wr_en & wr_strb[0];
  wire [31:0] status_word = {16'h0, ratio_seen, mode_seen, 2'h0, clock_error, missing, ratio_err, fs_err,
                             range_err, pll_over};
  wire [31:0] rd_data = (rd_sel == 2'h1) ? {24'h0, ratio_rate} :
                        (rd_sel == 2'h2) ? {24'h0, masks} :
                        (rd_sel == 2'h3) ? status_word : 32'h0;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ratio_rate <= acm_pkg::RATIO_RATE_RESET;
      masks <= acm_pkg::MASKS_RESET; // [RULE12]
    end else begin
      if (wr_low && wr_sel == 2'h1) ratio_rate <= wr_data[7:0]; // [RULE1] [RULE2]
      if (wr_low && wr_sel == 2'h2) masks <= wr_data[7:0];
    end
  end
  assign bit_clocks_per_frame = ratio_rate[7:4];
  assign sample_rate_mode = ratio_rate[3:0];

  acm_axil_slave u_slave (
    .clk(clk),
    .reset_n(reset_n),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // ****************************************
  // Checks
  // ****************************************
  logic [8:0] idle_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idle_cnt <= '0;
    end else begin
      idle_cnt <= bclk_rise ? '0 : ((idle_cnt == '1) ? idle_cnt : idle_cnt + 9'h001);
    end
  end

  sequence bclk_edge_s;
    bclk_rise;
  endsequence

  sequence frame_edge_s;
    frame_rise;
  endsequence

  ratio_field_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE1]
    (wr_low && wr_sel == 2'h1) |=> (bit_clocks_per_frame == $past(wr_data[7:4])))
    else $error("ratio field not stored");

  reserved_mode_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE2]
    (frame_edge_s and (ratio_rate[3:0] == 4'h1)) |=> fs_err)
    else $error("reserved rate mode not flagged");

  pll_rate_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE4]
    (bclk_edge_s and (int'(per_now) <= PLL_PER_CYC)) |=> pll_over)
    else $error("pll overrate missed");

  pll_mask_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE5]
    (pll_over && !masks[acm_pkg::MASK_PLL_BIT]) |=> clock_error)
    else $error("unmasked pll overrate without clock error");

  range_slow_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE6]
    (bclk_edge_s and too_slow) |=> range_err[*2])
    else $error("slow bit clock not flagged");

  range_mask_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE7]
    (range_err && !masks[acm_pkg::MASK_RANGE_BIT]) |=> clock_error)
    else $error("unmasked range error without clock error");

  fs_mask_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE8]
    (raw == 5'b00100 && masks[acm_pkg::MASK_FS_BIT] && !frame_rise) |=>
    (!clock_error && status_word[acm_pkg::ST_FS_BIT]))
    else $error("masked rate error leaked or hidden");

  ratio_range_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE9]
    (frame_edge_s and (int'(bits_now) > acm_pkg::RATIO_MAX)) |=> ratio_err)
    else $error("ratio above limit not flagged");

  ratio_mask_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE10]
    (raw == 5'b00010 && masks[acm_pkg::MASK_RATIO_BIT]) |=> !clock_error)
    else $error("masked ratio error leaked");

  miss_detect_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE11]
    (int'(idle_cnt) >= MISS_CYC + 1) |-> (missing && status_word[acm_pkg::ST_MISS_BIT]))
    else $error("missing bit clock not detected");

  all_masked_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE12]
    (mask_sel == 5'h1f) |=> !clock_error)
    else $error("clock error with all masks set");
endmodule

// file: shared/acm_pkg.sv
// Constants and helpers for the audio clock configuration monitor
package acm_pkg;
  // ****************************************
  // Clock and bus
  // ****************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int ADDR_W = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // Register indices, byte address is four times the index
  // ****************************************
  localparam logic [7:0] IDX_RATIO_RATE = 8'h28;
  localparam logic [7:0] IDX_MASKS = 8'h29;
  localparam logic [7:0] IDX_STATUS = 8'h2a;
  localparam logic [7:0] RATIO_RATE_RESET = 8'h00;
  localparam logic [7:0] MASKS_RESET = 8'h00;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int MASK_PLL_BIT = 6;
  localparam int MASK_RANGE_BIT = 5;
  localparam int MASK_FS_BIT = 4;
  localparam int MASK_RATIO_BIT = 3;
  localparam int MASK_MISS_BIT = 2;
  localparam int ST_PLL_BIT = 0;
  localparam int ST_RANGE_BIT = 1;
  localparam int ST_FS_BIT = 2;
  localparam int ST_RATIO_BIT = 3;
  localparam int ST_MISS_BIT = 4;
  localparam int ST_CLKERR_BIT = 5;
  localparam int ST_MODE_LSB = 8;
  localparam int ST_RATIO_LSB = 12;
  // ****************************************
  // Bit clocks per frame codes
  // ****************************************
  localparam logic [3:0] RATIO_32FS = 4'h3;
  localparam logic [3:0] RATIO_64FS = 4'h5;
  localparam logic [3:0] RATIO_128FS = 4'h7;
  localparam logic [3:0] RATIO_256FS = 4'h9;
  localparam logic [3:0] RATIO_512FS = 4'hb;
  localparam int RATIO_MIN = 32;
  localparam int RATIO_MAX = 512;
  // ****************************************
  // Sample rate mode codes and rates
  // ****************************************
  localparam logic [3:0] MODE_AUTO = 4'h0;
  localparam logic [3:0] MODE_8K = 4'h2;
  localparam logic [3:0] MODE_16K = 4'h4;
  localparam logic [3:0] MODE_32K = 4'h6;
  localparam logic [3:0] MODE_44K1 = 4'h8;
  localparam logic [3:0] MODE_48K = 4'h9;
  localparam logic [3:0] MODE_96K = 4'hb;
  localparam int FS_8K_HZ = 8000;
  localparam int FS_16K_HZ = 16000;
  localparam int FS_32K_HZ = 32000;
  localparam int FS_44K1_HZ = 44100;
  localparam int FS_48K_HZ = 48000;
  localparam int FS_88K2_HZ = 88200;
  localparam int FS_96K_HZ = 96000;
  localparam int FS_TOL_SHIFT = 4;
  localparam int FRAME_CNT_W = 12;
  // ****************************************
  // Bit clock timing
  // ****************************************
  localparam int BCLK_MIN_HZ = 256_000;
  localparam int BCLK_MAX_HZ = 50_000_000;
  localparam int PLL_LIMIT_HZ = 150_000_000;
  localparam int BCLK_MAX_PER_CYC = CLK_HZ / BCLK_MIN_HZ;
  localparam int BCLK_MIN_PER_CYC = (CLK_HZ + BCLK_MAX_HZ - 1) / BCLK_MAX_HZ;
  localparam int MISS_TIME_NS = 8000;
  localparam int MISS_CYC = MISS_TIME_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int PER_W = 8;
  localparam int BITS_W = 10;

  function automatic int fs_lo(input int hz);
    fs_lo = (CLK_HZ / hz) - ((CLK_HZ / hz) >> FS_TOL_SHIFT);
  endfunction

  function automatic int fs_hi(input int hz);
    fs_hi = (CLK_HZ / hz) + ((CLK_HZ / hz) >> FS_TOL_SHIFT);
  endfunction
endpackage
